// ===== src/spi_frame_pkg.sv
// constants and types shared by the framed serial port control block
package spi_frame_pkg;

	// ==================================================
	// register map (byte addresses on the apb bus)
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TXDATA = 8'h04;
	localparam logic [7:0] REG_RXDATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;

	// ==================================================
	// control register fields
	localparam int unsigned CTRL_EN_BIT = 15;
	localparam int unsigned CTRL_DIR_BIT = 14;
	localparam int unsigned CTRL_POL_BIT = 13;
	localparam int unsigned CTRL_EDGE_BIT = 1;
	localparam int unsigned CTRL_ENH_BIT = 0;
	localparam logic [15:0] CTRL_RESET = 16'h0000;

	// ==================================================
	// status register fields
	localparam int unsigned STAT_TX_FULL_BIT = 0;
	localparam int unsigned STAT_RX_VALID_BIT = 1;
	localparam int unsigned STAT_RX_OVF_BIT = 2;
	localparam int unsigned STAT_TX_BUSY_BIT = 3;

	// ==================================================
	// sizes and synchroniser depth
	localparam int unsigned WORD_W_DEF = 16;
	localparam int unsigned ENH_DEPTH_DEF = 4;
	localparam int unsigned SYNC_STAGES = 3;

	typedef struct packed {
		logic en;
		logic dir;
		logic pol;
		logic edge_sel;
		logic enh;
	} frame_cfg_t;

	typedef enum logic [2:0] {
		L_IDLE = 3'b001,
		L_SYNC = 3'b010,
		L_SHIFT = 3'b100
	} link_state_t;

endpackage : spi_frame_pkg

// ===== src/spi_framed_mode_control.sv
// framed serial port: control register, transmit buffer and link shifter
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns

module spi_framed_mode_control #(
	parameter int unsigned WORD_W = spi_frame_pkg::WORD_W_DEF,
	parameter int unsigned ENH_DEPTH = spi_frame_pkg::ENH_DEPTH_DEF
) (
	// system clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [spi_frame_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial link, own clock domain
	input wire logic link_clk,
	input wire logic sdi,
	output logic sdo,
	input wire logic select_pin_i,
	output logic select_pin_o,
	output logic select_pin_oe
);
	import spi_frame_pkg::*;

	localparam int unsigned PTR_W = (ENH_DEPTH > 1) ? $clog2(ENH_DEPTH) : 1;
	localparam int unsigned CNT_W = PTR_W + 1;
	localparam int unsigned BIT_W = $clog2(WORD_W + 1);
	localparam logic [CNT_W-1:0] DEPTH_ENH = CNT_W'(ENH_DEPTH);
	localparam logic [CNT_W-1:0] DEPTH_STD = CNT_W'(1);
	localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(WORD_W - 1);

	// ==================================================
	// register field packing
	function automatic logic [15:0] cfg_to_word(input frame_cfg_t c);
		logic [15:0] w;
		w = CTRL_RESET;
		w[CTRL_EN_BIT] = c.en;
		w[CTRL_DIR_BIT] = c.dir;
		w[CTRL_POL_BIT] = c.pol;
		w[CTRL_EDGE_BIT] = c.edge_sel;
		w[CTRL_ENH_BIT] = c.enh;
		return w;
	endfunction : cfg_to_word

	function automatic frame_cfg_t word_to_cfg(input logic [31:0] w);
		frame_cfg_t c;
		c.en = w[CTRL_EN_BIT];
		c.dir = w[CTRL_DIR_BIT];
		c.pol = w[CTRL_POL_BIT];
		c.edge_sel = w[CTRL_EDGE_BIT];
		c.enh = w[CTRL_ENH_BIT];
		return c;
	endfunction : word_to_cfg

	// ==================================================
	// state of both domains
	typedef struct packed {
		frame_cfg_t cfg;
		logic [ENH_DEPTH-1:0][WORD_W-1:0] mem;
		logic [PTR_W-1:0] wr_ptr;
		logic [PTR_W-1:0] rd_ptr;
		logic [CNT_W-1:0] count;
		logic [WORD_W-1:0] hold;
		logic req;
		logic [SYNC_STAGES-1:0] ack_s;
		logic ack_q;
		logic [SYNC_STAGES-1:0] done_s;
		logic done_q;
		logic [WORD_W-1:0] rx_data;
		logic rx_valid;
		logic rx_ovf;
		logic [31:0] prdata;
		logic pslverr;
	} sys_t;

	typedef struct packed {
		frame_cfg_t cfg_s0;
		frame_cfg_t cfg_s1;
		frame_cfg_t cfg_s2;
		frame_cfg_t cfg;
		logic [SYNC_STAGES-1:0] req_s;
		logic req_q;
		logic ack;
		link_state_t state;
		logic [BIT_W-1:0] bit_cnt;
		logic [WORD_W-1:0] tx_sh;
		logic [WORD_W-1:0] rx_sh;
		logic [WORD_W-1:0] rx_word;
		logic done;
		logic sdo;
		logic fs_pin;
	} lnk_t;

	sys_t s_r;
	sys_t s_nxt;
	lnk_t l_r;
	lnk_t l_nxt;

	// ==================================================
	// system domain: apb slave, buffer, crossings
	always_comb begin
		logic setup;
		logic acc;
		logic push;
		logic pop;
		logic [CNT_W-1:0] cap;
		setup = psel & ~penable;
		acc = psel & penable;
		cap = s_r.cfg.enh ? DEPTH_ENH : DEPTH_STD;
		push = 1'b0;
		pop = 1'b0;
		s_nxt = s_r;
		if (setup) begin
			s_nxt.pslverr = 1'b0;
			s_nxt.prdata = 32'h0000_0000;
			case (paddr)
				REG_CTRL: begin
					s_nxt.prdata[15:0] = cfg_to_word(s_r.cfg);
				end
				REG_TXDATA: begin
					s_nxt.prdata = 32'h0000_0000;
				end
				REG_RXDATA: begin
					s_nxt.prdata[WORD_W-1:0] = s_r.rx_data;
				end
				REG_STATUS: begin
					s_nxt.prdata[STAT_TX_FULL_BIT] = (s_r.count >= cap);
					s_nxt.prdata[STAT_RX_VALID_BIT] = s_r.rx_valid;
					s_nxt.prdata[STAT_RX_OVF_BIT] = s_r.rx_ovf;
					s_nxt.prdata[STAT_TX_BUSY_BIT] = (s_r.req != s_r.ack_q) | (s_r.count != '0);
				end
				default: begin
					s_nxt.pslverr = 1'b1;
				end
			endcase
		end
		if (acc && pwrite) begin
			case (paddr)
				REG_CTRL: begin
					s_nxt.cfg = word_to_cfg(pwdata);
				end
				REG_TXDATA: begin
					push = (s_r.count < cap);
				end
				REG_STATUS: begin
					if (pwdata[STAT_RX_OVF_BIT]) begin
						s_nxt.rx_ovf = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		if (acc && !pwrite && paddr == REG_RXDATA) begin
			s_nxt.rx_valid = 1'b0;
		end
		if (push) begin
			s_nxt.mem[s_r.wr_ptr] = pwdata[WORD_W-1:0];
			s_nxt.wr_ptr = s_r.wr_ptr + PTR_W'(1);
		end
		// holding word is free once the link has acknowledged the last one
		if (s_r.count != '0 && s_r.req == s_r.ack_q) begin
			pop = 1'b1;
			s_nxt.hold = s_r.mem[s_r.rd_ptr];
			s_nxt.req = ~s_r.req;
			s_nxt.rd_ptr = s_r.rd_ptr + PTR_W'(1);
		end
		s_nxt.count = s_r.count + CNT_W'(push) - CNT_W'(pop);
		s_nxt.ack_s = {s_r.ack_s[SYNC_STAGES-2:0], l_r.ack};
		if (s_r.ack_s[1] == s_r.ack_s[2]) begin
			s_nxt.ack_q = s_r.ack_s[2];
		end
		s_nxt.done_s = {s_r.done_s[SYNC_STAGES-2:0], l_r.done};
		if (s_r.done_s[1] == s_r.done_s[2]) begin
			s_nxt.done_q = s_r.done_s[2];
		end
		// received word is stable for a whole word time on the link side
		if (s_r.done_q != s_nxt.done_q) begin
			s_nxt.rx_data = l_r.rx_word;
			s_nxt.rx_valid = 1'b1;
			if (s_r.rx_valid && s_nxt.rx_valid) begin
				s_nxt.rx_ovf = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.prdata;
	assign pslverr = s_r.pslverr;
	assign pready = psel & penable;

	// ==================================================
	// link domain: frame sync and shifter
	always_comb begin
		logic pending;
		logic master;
		logic sel_act;
		logic pulse;
		logic [WORD_W-1:0] word;
		logic [WORD_W-1:0] rx_new;
		pending = (l_r.req_q != l_r.ack);
		master = l_r.cfg.en & ~l_r.cfg.dir;
		// unframed: select pin is a plain active-low chip select
		sel_act = l_r.cfg.en ? (select_pin_i == l_r.cfg.pol) : ~select_pin_i;
		word = pending ? s_r.hold : '0;
		rx_new = {l_r.rx_sh[WORD_W-2:0], sdi};
		pulse = 1'b0;
		l_nxt = l_r;
		l_nxt.cfg_s0 = s_r.cfg;
		l_nxt.cfg_s1 = l_r.cfg_s0;
		l_nxt.cfg_s2 = l_r.cfg_s1;
		if (l_r.cfg_s1 == l_r.cfg_s2) begin
			l_nxt.cfg = l_r.cfg_s2;
		end
		l_nxt.req_s = {l_r.req_s[SYNC_STAGES-2:0], s_r.req};
		if (l_r.req_s[1] == l_r.req_s[2]) begin
			l_nxt.req_q = l_r.req_s[2];
		end
		case (l_r.state)
			L_IDLE: begin
				l_nxt.sdo = 1'b0;
				if (master && pending) begin
					l_nxt.ack = l_r.req_q;
					pulse = 1'b1;
					l_nxt.bit_cnt = '0;
					if (l_r.cfg.edge_sel) begin
						l_nxt.sdo = s_r.hold[WORD_W-1];
						l_nxt.tx_sh = s_r.hold << 1;
						l_nxt.state = L_SHIFT;
					end else begin
						l_nxt.tx_sh = s_r.hold;
						l_nxt.state = L_SYNC;
					end
				end else if (!master && sel_act) begin
					l_nxt.ack = l_r.req_q;
					l_nxt.state = L_SHIFT;
					l_nxt.sdo = word[WORD_W-1];
					l_nxt.tx_sh = word << 1;
					if (l_r.cfg.en && l_r.cfg.edge_sel) begin
						// pulse marks the first data bit itself
						l_nxt.rx_sh = rx_new;
						l_nxt.bit_cnt = BIT_W'(1);
					end else begin
						l_nxt.bit_cnt = '0;
					end
				end
			end
			L_SYNC: begin
				l_nxt.sdo = l_r.tx_sh[WORD_W-1];
				l_nxt.tx_sh = l_r.tx_sh << 1;
				l_nxt.state = L_SHIFT;
			end
			L_SHIFT: begin
				l_nxt.rx_sh = rx_new;
				if (l_r.bit_cnt == LAST_BIT) begin
					l_nxt.rx_word = rx_new;
					l_nxt.done = ~l_r.done;
					l_nxt.sdo = 1'b0;
					l_nxt.state = L_IDLE;
				end else begin
					l_nxt.bit_cnt = l_r.bit_cnt + BIT_W'(1);
					l_nxt.sdo = l_r.tx_sh[WORD_W-1];
					l_nxt.tx_sh = l_r.tx_sh << 1;
				end
			end
			default: begin
				l_nxt.state = L_IDLE;
			end
		endcase
		l_nxt.fs_pin = l_r.cfg.pol ? pulse : ~pulse;
	end

	always_ff @(posedge link_clk or negedge arst_n) begin
		if (!arst_n) begin
			l_r <= '{state: L_IDLE, default: '0};
		end else begin
			l_r <= l_nxt;
		end
	end

	assign sdo = l_r.sdo;
	assign select_pin_o = l_r.fs_pin;
	assign select_pin_oe = l_r.cfg.en & ~l_r.cfg.dir;

endmodule : spi_framed_mode_control

// ===== tb/spi_frame_checker.sv
// pin-level assertions for the framed serial port
`timescale 1ns/1ns
module spi_frame_checker (
	// apb
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [spi_frame_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// link
	input wire logic link_clk,
	input wire logic select_pin_o,
	input wire logic select_pin_oe
);
	import spi_frame_pkg::*;
	logic [15:0] mir_r;
	logic [5:0] pol_l;
	logic acc;
	logic act;
	assign acc = psel && penable;
	// polarity counts only once steady on the link side for six bit clocks
	assign act = select_pin_oe && (&pol_l || !(|pol_l)) && (select_pin_o == pol_l[5]);
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			mir_r <= 16'h0000;
		else if (acc && pwrite && paddr == REG_CTRL)
			mir_r <= pwdata[15:0] & 16'he003;
	end
	always_ff @(posedge link_clk or negedge arst_n) begin
		if (!arst_n)
			pol_l <= 6'h00;
		else
			pol_l <= {pol_l[4:0], mir_r[13]};
	end
	ready_zero_wait_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		psel && !penable |=> pready) else $error("late answer");
	ctrl_rd_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		acc && !pwrite && paddr == REG_CTRL |-> prdata == {16'h0000, mir_r}) else $error("ctrl");
	reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		acc && paddr == REG_CTRL |-> prdata[12:2] == 11'h000) else $error("reserved");
	unmapped_err_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		acc && !pwrite && paddr > REG_STATUS |-> pslverr && prdata == 32'h0) else $error("err");
	status_okay_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		acc && paddr == REG_STATUS |-> !pslverr) else $error("okay");
	oe_on_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		$rose(select_pin_oe) |-> mir_r[15] && !mir_r[14]) else $error("oe");
	pulse_width_a: assert property (@(posedge link_clk) disable iff (!arst_n)
		$rose(act) |=> !act) else $error("pulse");
endmodule : spi_frame_checker
bind spi_framed_mode_control spi_frame_checker chk (.clk_sys, .arst_n, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link_clk, .select_pin_o,
	.select_pin_oe);

// ===== tb/spi_far_model.sv
// far serial slave: logs select and data per bit clock
`timescale 1ns/1ns
module spi_far_model (
	// link
	input wire logic link_clk,
	input wire logic sdo,
	input wire logic sel_o,
	input wire logic sel_oe,
	input wire logic clr,
	input wire logic fs_pulse,
	output logic sdi,
	output logic sel_i
);
	logic [1:0] log_r [0:63];
	logic [5:0] n_r;
	logic fs_q = 1'h0;
	logic lo_r = 1'h0;
	// pull-up when the device does not drive; one-bit active-low sync when asked
	assign sel_i = sel_oe ? sel_o : ~lo_r;
	always @(posedge link_clk) begin
		fs_q <= fs_pulse;
		lo_r <= fs_pulse && !fs_q;
		if (clr) begin
			n_r <= 6'h00;
			sdi <= 1'h0;
		end else begin
			sdi <= ~sdi;
			log_r[n_r] <= {sel_i, sdo};
			if (n_r != 6'h3f)
				n_r <= n_r + 6'h01;
		end
	end
endmodule : spi_far_model

// ===== tb/tb_top.sv
// self-checking bench for the framed serial port
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
	import spi_frame_pkg::*;
	localparam int DEPTH = 4;
	logic clk_sys = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, link_clk = 0, clr = 1;
	logic fs_pulse = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, sdi, sdo, sel_i, sel_o, sel_oe;
	int num_errors = 0, n_compared = 0, cyc = 0;
	always #10 clk_sys = ~clk_sys;
	initial begin
		#7;
		forever #24 link_clk = ~link_clk;
	end
	spi_framed_mode_control #(.WORD_W(16), .ENH_DEPTH(DEPTH)) dut (.clk_sys, .arst_n, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link_clk, .sdi, .sdo,
		.select_pin_i(sel_i), .select_pin_o(sel_o), .select_pin_oe(sel_oe));
	spi_far_model far (.link_clk, .sdo, .sel_o, .sel_oe, .clr, .fs_pulse, .sdi, .sel_i);
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			summarize();
		end
	end
	task automatic summarize();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize
	task automatic rst();
		arst_n <= 1'h0;
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'h1;
	endtask : rst
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		do @(posedge clk_sys); while (pready !== 1'h1);
		rd = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic t_regs();
		apb(1'h0, REG_CTRL, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'h1, REG_CTRL, 32'hffff_ffff);
		apb(1'h0, REG_CTRL, 32'h0);
		`CHK(rd, 32'h0000_e003)
		for (int b = 0; b < 16; b++) begin
			apb(1'h1, REG_CTRL, 32'h1 << b);
			apb(1'h0, REG_CTRL, 32'h0);
			`CHK(rd, (32'h1 << b) & 32'he003)
		end
		apb(1'h0, 8'h10, 32'h0);
		`CHK({pslverr, rd}, 33'h1_0000_0000)
	endtask : t_regs
	task automatic fill(input logic [31:0] c, output int n);
		apb(1'h1, REG_CTRL, c);
		repeat (20) @(posedge clk_sys);
		n = 0;
		do begin
			apb(1'h1, REG_TXDATA, 32'h1234);
			n++;
			repeat (20) @(posedge clk_sys);
			apb(1'h0, REG_STATUS, 32'h0);
		end while (rd[STAT_TX_FULL_BIT] !== 1'h1 && n < 12);
	endtask : fill
	task automatic t_buf();
		int ns, ne;
		fill(32'h0, ns);
		rst();
		fill(32'h1, ne);
		rst();
		`CHK(ne - ns, DEPTH - 1)
	endtask : t_buf
	task automatic t_master(input logic e, input logic p);
		int k;
		k = -1;
		apb(1'h1, REG_CTRL, {18'h0, p, 13'h0});
		repeat (20) @(posedge clk_sys);
		apb(1'h1, REG_CTRL, {16'h0, 2'h2, p, 11'h0, e, 1'h0});
		repeat (20) @(posedge clk_sys);
		`CHK(sel_oe, 1'h1)
		clr <= 1'h0;
		apb(1'h1, REG_TXDATA, 32'h0000_b38d);
		do apb(1'h0, REG_STATUS, 32'h0); while (rd[STAT_TX_BUSY_BIT] !== 1'h0);
		// busy drops when the frame starts, so wait out the whole frame
		repeat (60) @(posedge clk_sys);
		for (int i = 63; i >= 0; i--) if (far.log_r[i][1] === p) k = i;
		`CHK(k >= 0, 1'h1)
		`CHK(far.log_r[k + 1][1], ~p)
		for (int i = 0; i < 16; i++) `CHK(far.log_r[k + 1 - e + i][0], 16'hb38d >> (15 - i) & 1'h1)
		apb(1'h0, REG_RXDATA, 32'h0);
		`CHK(rd[15:0] == 16'haaaa || rd[15:0] == 16'h5555, 1'h1)
		clr <= 1'h1;
	endtask : t_master
	task automatic t_slave();
		int k;
		k = -1;
		apb(1'h1, REG_CTRL, 32'h4000);
		repeat (20) @(posedge clk_sys);
		`CHK(sel_oe, 1'h0)
		clr <= 1'h0;
		apb(1'h1, REG_TXDATA, 32'h0000_b38d);
		repeat (20) @(posedge clk_sys);
		fs_pulse <= 1'h1;
		repeat (60) @(posedge clk_sys);
		for (int i = 63; i >= 0; i--) if (far.log_r[i][1] === 1'h0) k = i;
		`CHK(k >= 0, 1'h1)
		for (int i = 0; i < 16; i++) `CHK(far.log_r[k + 1 + i][0], 16'hb38d >> (15 - i) & 1'h1)
		apb(1'h0, REG_RXDATA, 32'h0);
		`CHK(rd[15:0] == 16'haaaa || rd[15:0] == 16'h5555, 1'h1)
		fs_pulse <= 1'h0;
		clr <= 1'h1;
	endtask : t_slave
	task automatic t_dir();
		apb(1'h1, REG_CTRL, 32'he000);
		repeat (20) @(posedge clk_sys);
		`CHK(sel_oe, 1'h0)
		apb(1'h1, REG_CTRL, 32'ha000);
		repeat (20) @(posedge clk_sys);
		`CHK(sel_oe, 1'h1)
		apb(1'h1, REG_CTRL, 32'h2000);
		repeat (20) @(posedge clk_sys);
		`CHK(sel_oe, 1'h0)
	endtask : t_dir
	initial begin
		rst();
		t_regs();
		t_buf();
		for (int i = 0; i < 4; i++) t_master(i[1], i[0]);
		t_slave();
		t_dir();
		summarize();
	end
endmodule : tb_top
